// File: rtl/rdc_top.sv
// Reset driver control pins, serial port and AXI4-Lite registers
//
// Notes on behaviour
// - Rising strobe edge captures mode, level and group select together.
// - Two-bit mode select chooses the driver operating mode.
// - Two-bit level select chooses the driver output level.
// - Driver outputs enabled only while the active-low output enable is low.
// - Output enable reads high when undriven, so drivers start disabled.
// - Init input low forces driver state to the offset level.
// - Serial data in is sampled on the serial clock rising edge.
// - Serial select is active low and opens a transfer.
// - Read data returns on the dedicated serial data output.
// - Three active-high enables switch the bias, offset and reset regulators.
// - Interrupt to the controller is signalled by driving the output low.
// - Four-bit group select is captured with the other driver controls.
`include "rdc_defs.svh"
module rdc_top
   import rdc_pkg::*;
#(
   parameter int SER_W = 16
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [`RDC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [`RDC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Driver control pins
   input wire logic [1:0] drv_mode_sel,
   input wire logic [1:0] drv_level_sel,
   input wire logic [3:0] drv_group_sel,
   input wire logic drv_strobe,
   input wire logic drv_out_en_n,
   input wire logic drv_init_n,
   // Driver state
   output logic [1:0] drv_mode,
   output logic [1:0] drv_level,
   output logic [3:0] drv_group,
   output logic drv_enable,
   output logic drv_at_offset,
   // Serial port
   input wire logic ser_port_clk,
   input wire logic ser_port_din,
   input wire logic ser_port_sel_n,
   output logic ser_port_dout,
   // Regulator enables and interrupt
   output logic bias_level_en,
   output logic offset_level_en,
   output logic neg_rst_level_en,
   output logic ctrl_irq_n
);
   rdc_pins_type pins_raw;
   rdc_pins_type pins_f;
   rdc_pins_type pins_p_q;
   rdc_drv_ctrl_type drv_q;
   logic drv_enable_q;
   logic drv_at_offset_q;
   logic strobe_rise;
   logic init_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic [`RDC_CTRL_W-1:0] ctrl_q;
   logic [`RDC_IRQ_W-1:0] mask_q;
   logic [`RDC_IRQ_W-1:0] stat_q;
   logic [`RDC_IRQ_W-1:0] stat_set;
   logic [`RDC_IRQ_W-1:0] stat_clr;
   logic irq_n_q;
   logic [SER_W-1:0] tx_q;
   logic [SER_W-1:0] rx_word;
   logic [`RDC_CNT_W-1:0] rx_bits;
   logic ser_done;
   logic ser_busy;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [`RDC_ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic rd_take;
   logic [31:0] rd_val;
   logic [31:0] wr_ctrl;
   logic [31:0] wr_mask;
   logic [31:0] wr_tx;

   // True for a word offset that holds a register
   function automatic logic rdc_mapped(input logic [`RDC_ADDR_W-1:0] a);
      logic ok;
      ok = 1'b0;
      case (a)
         `RDC_OFF_CTRL, `RDC_OFF_STATUS, `RDC_OFF_IRQ_STAT, `RDC_OFF_IRQ_MASK,
         `RDC_OFF_SER_RX, `RDC_OFF_SER_TX, `RDC_OFF_SER_CNT: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Byte-lane merge of write data into an old value
   function automatic logic [31:0] rdc_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign pins_raw = {drv_group_sel, drv_level_sel, drv_mode_sel, drv_strobe, drv_out_en_n,
                      drv_init_n, ser_port_clk, ser_port_din, ser_port_sel_n};

   rdc_sync #(
      .WIDTH(`RDC_PIN_W),
      .RST_VAL(`RDC_PIN_RST)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(pins_raw),
      .level_q(pins_f)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_p_q <= `RDC_PIN_RST;
      end else begin
         pins_p_q <= pins_f;
      end
   end

   assign strobe_rise = pins_f.strobe & ~pins_p_q.strobe;
   assign init_fall = ~pins_f.init_n & pins_p_q.init_n;
   // edges counted only inside a frame
   assign sclk_rise = pins_f.sclk & ~pins_p_q.sclk & ~pins_f.sel_n;
   assign sclk_fall = ~pins_f.sclk & pins_p_q.sclk & ~pins_f.sel_n;

   // Driver control capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drv_q <= '0;
         drv_at_offset_q <= 1'b1;
      end else if (!pins_f.init_n) begin
         drv_q <= '0;
         drv_at_offset_q <= 1'b1;
      end else if (strobe_rise) begin
         drv_q <= pins_f.ctrl;
         drv_at_offset_q <= 1'b0;
      end
   end

   // Driver output enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drv_enable_q <= 1'b0;
      end else begin
         drv_enable_q <= ~pins_f.out_en_n & pins_f.init_n;
      end
   end

   rdc_ser_port #(
      .WIDTH(SER_W)
   ) u_ser (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel_n(pins_f.sel_n),
      .clk_rise(sclk_rise),
      .clk_fall(sclk_fall),
      .din(pins_f.din),
      .dout_q(ser_port_dout),
      .tx_word(tx_q),
      .rx_word_q(rx_word),
      .rx_bits_q(rx_bits),
      .done_q(ser_done),
      .busy_q(ser_busy)
   );

   // AXI write address and data, taken in either order
   assign do_write = aw_hold_q & w_hold_q & ~bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= `RDC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            awaddr_q <= s_axi_awaddr;
            aw_hold_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_hold_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (rdc_mapped(awaddr_q)) ? `RDC_RESP_OKAY : `RDC_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   always_comb begin
      wr_ctrl = rdc_merge(32'(ctrl_q), wdata_q, wstrb_q);
      wr_mask = rdc_merge(32'(mask_q), wdata_q, wstrb_q);
      wr_tx = rdc_merge(32'(tx_q), wdata_q, wstrb_q);
   end

   // Writable registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `RDC_CTRL_RST;
         mask_q <= `RDC_IRQ_RST;
         tx_q <= '0;
      end else if (do_write) begin
         case (awaddr_q)
            `RDC_OFF_CTRL: ctrl_q <= wr_ctrl[`RDC_CTRL_W-1:0];
            `RDC_OFF_IRQ_MASK: mask_q <= wr_mask[`RDC_IRQ_W-1:0];
            `RDC_OFF_SER_TX: tx_q <= wr_tx[SER_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Read data selection
   always_comb begin
      rd_val = 32'h0;
      case (s_axi_araddr)
         `RDC_OFF_CTRL: rd_val = 32'(ctrl_q);
         `RDC_OFF_STATUS: rd_val = 32'({ser_busy, pins_f.init_n, drv_enable_q,
                                        drv_at_offset_q, drv_q});
         `RDC_OFF_IRQ_STAT: rd_val = 32'(stat_q);
         `RDC_OFF_IRQ_MASK: rd_val = 32'(mask_q);
         `RDC_OFF_SER_RX: rd_val = 32'(rx_word);
         `RDC_OFF_SER_TX: rd_val = 32'(tx_q);
         `RDC_OFF_SER_CNT: rd_val = 32'(rx_bits);
         default: rd_val = 32'h0;
      endcase
   end

   assign rd_take = s_axi_arvalid & arready_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= `RDC_RESP_OKAY;
         rdata_q <= 32'h0;
      end else if (rd_take) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_val;
         rresp_q <= (rdc_mapped(s_axi_araddr)) ? `RDC_RESP_OKAY : `RDC_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Sticky events; a new event beats the read-clear
   always_comb begin
      stat_set = '0;
      stat_set[`RDC_IRQ_STROBE] = strobe_rise & pins_f.init_n;
      stat_set[`RDC_IRQ_FRAME] = ser_done;
      stat_set[`RDC_IRQ_INIT] = init_fall;
      stat_clr = (rd_take && s_axi_araddr == `RDC_OFF_IRQ_STAT) ? '1 : '0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= `RDC_IRQ_RST;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= ~|(stat_q & mask_q);
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign drv_mode = drv_q.mode;
   assign drv_level = drv_q.level;
   assign drv_group = drv_q.group;
   assign drv_enable = drv_enable_q;
   assign drv_at_offset = drv_at_offset_q;
   assign bias_level_en = ctrl_q[`RDC_CTRL_BIAS];
   assign offset_level_en = ctrl_q[`RDC_CTRL_OFFSET];
   assign neg_rst_level_en = ctrl_q[`RDC_CTRL_NEG_RST];
   assign ctrl_irq_n = irq_n_q;
endmodule

// File: rtl/rdc_defs.svh
// Register map, field positions and reset values of the reset driver control block
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH
`define RDC_ADDR_W 5
`define RDC_OFF_CTRL 5'h00
`define RDC_OFF_STATUS 5'h04
`define RDC_OFF_IRQ_STAT 5'h08
`define RDC_OFF_IRQ_MASK 5'h0c
`define RDC_OFF_SER_RX 5'h10
`define RDC_OFF_SER_TX 5'h14
`define RDC_OFF_SER_CNT 5'h18
`define RDC_CTRL_W 3
`define RDC_CTRL_RST 3'h0
`define RDC_CTRL_BIAS 0
`define RDC_CTRL_OFFSET 1
`define RDC_CTRL_NEG_RST 2
`define RDC_IRQ_W 3
`define RDC_IRQ_RST 3'h0
`define RDC_IRQ_STROBE 0
`define RDC_IRQ_FRAME 1
`define RDC_IRQ_INIT 2
`define RDC_RESP_OKAY 2'h0
`define RDC_RESP_SLVERR 2'h2
`define RDC_PIN_W 14
`define RDC_PIN_RST 14'h0011
`define RDC_CNT_W 8
`define RDC_CNT_MAX 8'hff
`endif

// File: rtl/rdc_pkg.sv
// Types shared by the reset driver control block
package rdc_pkg;
   typedef struct packed {
      logic [3:0] group;
      logic [1:0] level;
      logic [1:0] mode;
   } rdc_drv_ctrl_type;

   typedef struct packed {
      rdc_drv_ctrl_type ctrl;
      logic strobe;
      logic out_en_n;
      logic init_n;
      logic sclk;
      logic din;
      logic sel_n;
   } rdc_pins_type;

   typedef enum logic {
      RDC_SER_IDLE,
      RDC_SER_SHIFT
   } rdc_ser_state_type;
endpackage

// File: rtl/rdc_sync.sv
// Three-stage pin synchroniser with agreement filter
module rdc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pins and filtered levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_q
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         level_q <= RST_VAL;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // A bit changes only once stages two and three agree
         level_q <= (s3_q & ~(s2_q ^ s3_q)) | (level_q & (s2_q ^ s3_q));
      end
   end
endmodule

// File: rtl/rdc_ser_port.sv
// Serial port shift engine framed by the select level
`include "rdc_defs.svh"
module rdc_ser_port
   import rdc_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Filtered link signals
   input wire logic sel_n,
   input wire logic clk_rise,
   input wire logic clk_fall,
   input wire logic din,
   output logic dout_q,
   // Words
   input wire logic [WIDTH-1:0] tx_word,
   output logic [WIDTH-1:0] rx_word_q,
   output logic [`RDC_CNT_W-1:0] rx_bits_q,
   output logic done_q,
   output logic busy_q
);
   rdc_ser_state_type state_q;
   logic [WIDTH-1:0] rx_sh_q;
   logic [WIDTH-1:0] tx_sh_q;
   logic [`RDC_CNT_W-1:0] cnt_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= RDC_SER_IDLE;
         rx_sh_q <= '0;
         tx_sh_q <= '0;
         cnt_q <= '0;
         rx_word_q <= '0;
         rx_bits_q <= '0;
         done_q <= 1'b0;
         dout_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            RDC_SER_IDLE: begin
               if (!sel_n) begin
                  state_q <= RDC_SER_SHIFT;
                  busy_q <= 1'b1;
                  rx_sh_q <= '0;
                  cnt_q <= '0;
                  tx_sh_q <= tx_word;
                  dout_q <= tx_word[WIDTH-1];
               end
            end
            RDC_SER_SHIFT: begin
               if (sel_n) begin
                  state_q <= RDC_SER_IDLE;
                  busy_q <= 1'b0;
                  rx_word_q <= rx_sh_q;
                  rx_bits_q <= cnt_q;
                  done_q <= 1'b1;
                  dout_q <= 1'b0;
               end else if (clk_rise) begin
                  rx_sh_q <= {rx_sh_q[WIDTH-2:0], din};
                  if (cnt_q != `RDC_CNT_MAX) begin
                     cnt_q <= cnt_q + 1'b1;
                  end
               end else if (clk_fall) begin
                  tx_sh_q <= {tx_sh_q[WIDTH-2:0], 1'b0};
                  dout_q <= tx_sh_q[WIDTH-2];
               end
            end
            default: begin
               state_q <= RDC_SER_IDLE;
            end
         endcase
      end
   end
endmodule

// File: verif/rdc_top_properties.sv
// Concurrent checks on the ports of the reset driver control block
`include "rdc_defs.svh"
module rdc_top_checker #(
   parameter int SER_W = 16
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Driver pins and state
   input wire logic [1:0] drv_mode_sel,
   input wire logic [1:0] drv_level_sel,
   input wire logic [3:0] drv_group_sel,
   input wire logic drv_strobe,
   input wire logic drv_out_en_n,
   input wire logic drv_init_n,
   input wire logic [1:0] drv_mode,
   input wire logic [1:0] drv_level,
   input wire logic [3:0] drv_group,
   input wire logic drv_enable,
   input wire logic drv_at_offset,
   // Serial port, regulators and interrupt
   input wire logic ser_port_sel_n,
   input wire logic ser_port_dout,
   input wire logic bias_level_en,
   input wire logic offset_level_en,
   input wire logic neg_rst_level_en,
   input wire logic ctrl_irq_n
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_strobe_capture: assert property ($rose(drv_strobe) && drv_init_n |-> ##6
      (drv_group == $past(drv_group_sel, 6) && drv_level == $past(drv_level_sel, 6) &&
       drv_mode == $past(drv_mode_sel, 6) && !drv_at_offset))
      else $error("driver selects not captured on strobe");
   a_enable_on: assert property ((!drv_out_en_n && drv_init_n) [*8] |-> drv_enable)
      else $error("driver not enabled");
   a_enable_off: assert property (drv_out_en_n [*8] |-> !drv_enable)
      else $error("driver enabled while output enable high");
   a_init_offset: assert property (!drv_init_n [*8] |-> drv_at_offset && !drv_enable &&
      {drv_group, drv_level, drv_mode} == 8'h00) else $error("init low did not force offset");
   a_dout_idle: assert property (ser_port_sel_n [*8] |-> !ser_port_dout)
      else $error("serial output active outside frame");
   a_regulator_write: assert property (
      $changed({neg_rst_level_en, offset_level_en, bias_level_en}) |-> $rose(s_axi_bvalid))
      else $error("regulator enable moved without a write");
   a_irq_release: assert property (
      $rose(ctrl_irq_n) |-> $past(s_axi_rvalid) || $past(s_axi_bvalid))
      else $error("interrupt released without a bus access");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

   c_strobe: cover property ($rose(drv_strobe) && drv_init_n);
   c_frame: cover property ($rose(ser_port_sel_n));
   c_irq: cover property ($fell(ctrl_irq_n));
endmodule

bind rdc_top rdc_top_checker #(.SER_W(SER_W)) u_checker (.*);

// File: verif/rdc_ctrl_model.sv
// Display controller model driving the serial port pins
module rdc_ctrl_model (
   // Link pins
   output logic sclk,
   output logic din,
   output logic sel_n,
   input wire logic dout
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] cap;

   initial begin
      sclk = 1'b0;
      din = 1'b0;
      sel_n = 1'b1;
      cap = '0;
   end

   // Sends the low n bits of w and captures the returned bits
   task automatic frame(input logic [31:0] w, input int n);
      cap = '0;
      sel_n = 1'b0;
      #200;
      for (int i = n - 1; i >= 0; i--) begin
         din = w[i];
         #100;
         sclk = 1'b1;
         #90;
         cap = {cap[30:0], dout};
         #10;
         sclk = 1'b0;
      end
      #100;
      // Pull-down takes the released data line
      din = 1'b0;
      #100;
      sel_n = 1'b1;
      #400;
   endtask
endmodule

// File: verif/testbench.sv
// Self-checking bench for the reset driver control block
`include "rdc_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [`RDC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, w;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, drv_mode, drv_level, drv_mode_sel = '0, drv_level_sel = '0;
   logic [3:0] drv_group, drv_group_sel = '0;
   logic drv_strobe = 1'b0, drv_out_en_n = 1'b1, drv_init_n = 1'b1;
   logic drv_enable, drv_at_offset, ser_port_dout, bias_level_en, offset_level_en, neg_rst_level_en, ctrl_irq_n;
   wire logic ser_port_clk, ser_port_din, ser_port_sel_n;
   logic [33:0] exp_q[$];
   logic [31:0] seed = 32'd74589;
   int error_cnt = 0, compares = 0;

   always #12.5 aclk = ~aclk;

   rdc_top #(.SER_W(16)) dut (.*);
   rdc_ctrl_model ctl (.sclk(ser_port_clk), .din(ser_port_din), .sel_n(ser_port_sel_n), .dout(ser_port_dout));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] resp);
      logic aw, wd, b;
      aw = 1'b1;
      wd = 1'b1;
      b = 1'b1;
      @(posedge aclk);
      exp_q.push_back({resp, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || wd || b) begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (wd && s_axi_wready) begin
            wd = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
         if (b && s_axi_bvalid) begin
            b = 1'b0;
            s_axi_bready <= 1'b0;
         end
      end
   endtask

   task automatic rd(input logic [4:0] a, input logic [33:0] e);
      logic ar, r;
      ar = 1'b1;
      r = 1'b1;
      @(posedge aclk);
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (ar || r) begin
         @(posedge aclk);
         if (ar && s_axi_arready) begin
            ar = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         if (r && s_axi_rvalid) begin
            r = 1'b0;
            s_axi_rready <= 1'b0;
         end
      end
   endtask

   // Selects held stable around the strobe pulse
   task automatic strobe(input logic [7:0] s);
      @(posedge aclk);
      {drv_group_sel, drv_level_sel, drv_mode_sel} <= s;
      cyc(6);
      drv_strobe <= 1'b1;
      cyc(6);
      drv_strobe <= 1'b0;
      cyc(8);
   endtask

   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready)
         check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         check({s_axi_bresp, 32'h0}, exp_q.pop_front());
   end

   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end

   initial begin
      logic [7:0] s;
      cyc(8);
      aresetn <= 1'b1;
      cyc(8);
      rd(`RDC_OFF_CTRL, 34'h0);
      rd(`RDC_OFF_IRQ_MASK, 34'h0);
      rd(`RDC_OFF_IRQ_STAT, 34'h0);
      rd(`RDC_OFF_STATUS, 34'h500);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         wr(`RDC_OFF_CTRL, 32'(i), `RDC_RESP_OKAY);
         cyc(1);
         check({31'h0, neg_rst_level_en, offset_level_en, bias_level_en}, 34'(i));
         rd(`RDC_OFF_CTRL, 34'(i));
      end
      wr(5'h1c, 32'h0, `RDC_RESP_SLVERR);
      rd(5'h1c, {`RDC_RESP_SLVERR, 32'h0});
      rd(5'h01, {`RDC_RESP_SLVERR, 32'h0});
      rd(`RDC_OFF_CTRL, 34'h7);
      s_axi_wstrb <= 4'he;
      wr(`RDC_OFF_CTRL, 32'h0, `RDC_RESP_OKAY);
      rd(`RDC_OFF_CTRL, 34'h7);
      s_axi_wstrb <= 4'hf;
      $display("test registers done");
      wr(`RDC_OFF_IRQ_MASK, 32'h7, `RDC_RESP_OKAY);
      rd(`RDC_OFF_IRQ_MASK, 34'h7);
      for (int i = 0; i < 4; i++) begin
         w = rnd();
         s = {w[3:0], 2'(3 - i), 2'(i)};
         drv_out_en_n <= i[0];
         strobe(s);
         check({26'h0, drv_group, drv_level, drv_mode}, {26'h0, s});
         check({32'h0, drv_enable, drv_at_offset}, {32'h0, ~i[0], 1'b0});
         check({33'h0, ctrl_irq_n}, 34'h0);
         rd(`RDC_OFF_STATUS, {24'h1, ~i[0], 1'b0, s});
         rd(`RDC_OFF_IRQ_STAT, 34'h1);
         cyc(2);
         check({33'h0, ctrl_irq_n}, 34'h1);
      end
      $display("test strobe done");
      wr(`RDC_OFF_IRQ_MASK, 32'h3, `RDC_RESP_OKAY);
      drv_init_n <= 1'b0;
      strobe(8'hff);
      check({33'h0, ctrl_irq_n}, 34'h1);
      rd(`RDC_OFF_STATUS, 34'h100);
      check({24'h0, drv_group, drv_level, drv_mode, drv_enable, drv_at_offset}, 34'h1);
      rd(`RDC_OFF_IRQ_STAT, 34'h4);
      drv_init_n <= 1'b1;
      drv_out_en_n <= 1'b1;
      cyc(8);
      $display("test init done");
      for (int i = 0; i < 2; i++) begin
         w = rnd();
         wr(`RDC_OFF_SER_TX, {16'h0, w[31:16]}, `RDC_RESP_OKAY);
         ctl.frame(w, 16 + 4 * i);
         check({18'h0, 16'(ctl.cap >> (4 * i))}, {18'h0, w[31:16]});
         check({33'h0, ctrl_irq_n}, 34'h0);
         rd(`RDC_OFF_SER_RX, {18'h0, w[15:0]});
         rd(`RDC_OFF_SER_CNT, 34'(16 + 4 * i));
         rd(`RDC_OFF_SER_TX, {18'h0, w[31:16]});
         rd(`RDC_OFF_IRQ_STAT, 34'h2);
      end
      $display("test serial done");
      print_verdict();
   end
endmodule
